// ---- logic/external_bus_interface.v ----
// external pin interface: input sampling, bus handover, memory read strobe
// holds the pin synchronisers, the bus hand-over to an outside master and
// the read sequencer that stretches the read strobe by wait states
// assumes inputs arrive asynchronously; core drives one read per request
// assumes the far side floats its own drivers while the grant is high
//
// Functional notes
// - sample interrupts and flag input every cycle
// - sample bus request every cycle, pulse >10 ns; the code can miss a pulse shorter than one 50 ns cycle
// - grant asserted cycle after request recognized; the code grants two cycles after recognition
// - bus request synchronised internally
// - strobes released before grant, driven after
// - each wait state adds one clock
`timescale 1ns/10ps
`include "ext_bus_consts.vh"

module external_bus_interface (
    input  wire                      mclk,
    input  wire                      rst,
    input  wire [`IRQ_COUNT-1:0]     external_interrupt_n,
    input  wire                      flag_input,
    input  wire                      bus_request_n,
    input  wire                      rdReq,
    input  wire [1:0]                rdSpace,
    input  wire [`ADDR_WIDTH-1:0]    rdAddr,
    input  wire [`WAIT_WIDTH-1:0]    waitStates,
    input  wire [`DATA_WIDTH-1:0]    memData,
    output wire                      rdReady,
    output reg                       rdDone_ff,
    output reg  [`DATA_WIDTH-1:0]    rdData_ff,
    output reg  [`IRQ_COUNT-1:0]     irqSeen_ff,
    output reg                       flagSeen_ff,
    output reg                       bus_grant_n,
    output reg  [`ADDR_WIDTH-1:0]    addr_ff,
    output reg                       program_memory_select_n,
    output reg                       data_memory_select_n,
    output reg                       boot_memory_select_n,
    output reg                       readStrobe_n,
    output reg                       writeStrobe_n,
    output wire                      strobeOe
);

    // read sequencer states, one-hot
    localparam [2:0] ST_IDLE = 3'h1;   // no access
    localparam [2:0] ST_RD   = 3'h2;   // strobe low
    localparam [2:0] ST_HOLD = 3'h4;   // bus handed over

    // synchroniser, sequencer and hand-over registers
    reg  [`IRQ_COUNT-1:0]  irqMeta_ff;      // first sync stage
    reg                    flagMeta_ff;     // first sync stage
    reg                    reqMeta_ff;      // first sync stage
    reg                    reqSeen_ff;      // recognised request, active low
    reg  [2:0]             state_ff;        // sequencer state
    reg  [2:0]             nxt_state;       // next state
    reg  [`WAIT_WIDTH-1:0] waitCnt_ff;      // remaining wait clocks
    reg  [`WAIT_WIDTH-1:0] nxt_waitCnt;     // next wait count
    reg                    driveEn_ff;      // strobes driven

    ////////////////////////////////////////////////////////////////////////
    // input sampling: two flops per input, every cycle
    // the first stage may go metastable on an asynchronous edge; only
    // the second stage is read by the rest of the block
    // a pulse shorter than one cycle can be missed; the outside source
    // must respect the minimum pulse widths of the pins
    always @(posedge mclk) begin
        if (rst) begin
            irqMeta_ff  <= {`IRQ_COUNT{`SYNC_RESET_VAL}};
            irqSeen_ff  <= {`IRQ_COUNT{`SYNC_RESET_VAL}};
            flagMeta_ff <= 1'h0;
            flagSeen_ff <= 1'h0;
            reqMeta_ff  <= `SYNC_RESET_VAL;
            reqSeen_ff  <= `SYNC_RESET_VAL;
        end else begin
            // irq levels passed as seen; edge/level mode is the core's
            irqMeta_ff  <= external_interrupt_n;
            irqSeen_ff  <= irqMeta_ff;
            flagMeta_ff <= flag_input;
            flagSeen_ff <= flagMeta_ff;
            // request may be asynchronous; no outside sync needed
            reqMeta_ff  <= bus_request_n;
            reqSeen_ff  <= reqMeta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer next state
    // reads are taken only when idle, no request is pending and the
    // strobes are driven; a refused request simply waits
    assign rdReady = state_ff[0] && reqSeen_ff && driveEn_ff;

    // next state: idle, read with stretch, or hold for the outside master
    // a pending request beats a new read; a read in flight runs out first
    // the wait count is loaded when the read is taken and counts down
    // once per clock; the strobe stays low until the count reaches zero
    // so a read with no wait states keeps the strobe low one clock
    // after leaving hold the sequencer waits in idle until the strobes
    // are driven again, which keeps reads off a bus still handed over
    always @* begin
        nxt_state   = state_ff;
        nxt_waitCnt = waitCnt_ff;
        case (state_ff)
            ST_IDLE: begin
                if (!reqSeen_ff) begin
                    // bus request wins over a new read
                    nxt_state = ST_HOLD;
                end else if (rdReq && driveEn_ff) begin
                    nxt_state   = ST_RD;
                    nxt_waitCnt = waitStates;
                end
            end
            ST_RD: begin
                // one clock plus one per wait state
                if (waitCnt_ff == `WAIT_ZERO) begin
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_waitCnt = waitCnt_ff - `WAIT_ONE;
                end
            end
            ST_HOLD: begin
                // stay while request stays low
                if (reqSeen_ff) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // hand-over timeline, one line per processor cycle:
    //   c0  bus request pin goes low, any time within the cycle
    //   c1  first sync stage holds it
    //   c2  request recognised; a read in flight is finished first
    //   c3  strobes and selects released, sequencer in hold
    //   c4  grant driven low, the outside master owns the bus
    // and back again once the pin returns high:
    //   n2  withdrawal recognised, sequencer back to idle next cycle
    //   n3  grant returns high, strobes still released
    //   n4  strobes driven again, reads may start
    // the spare cycle at n3 keeps the two masters from overlapping
    // a request that is recognised again during n3 goes straight back to hold
    // without ever driving the strobes in between

    ////////////////////////////////////////////////////////////////////////
    // sequencer state and wait counter
    always @(posedge mclk) begin
        if (rst) begin
            state_ff   <= ST_IDLE;     // no access after reset
            waitCnt_ff <= `WAIT_ZERO;  // no stretch pending
        end else begin
            state_ff   <= nxt_state;
            waitCnt_ff <= nxt_waitCnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus hand-over: strobe release and grant
    always @(posedge mclk) begin
        if (rst) begin
            driveEn_ff  <= 1'h1;       // core owns the bus after reset
            bus_grant_n <= 1'h1;       // no grant after reset
        end else begin
            if (state_ff[0] && !reqSeen_ff) begin
                // release strobes now, grant follows next cycle
                driveEn_ff <= 1'h0;
            end else if (state_ff[0] && bus_grant_n && !driveEn_ff) begin
                // grant high a full cycle: take strobes back
                driveEn_ff <= 1'h1;
            end
            if (state_ff[2]) begin
                // grant two cycles after recognition, held while low
                bus_grant_n <= reqSeen_ff;
            end else begin
                // outside hold the grant stays high
                bus_grant_n <= 1'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read strobe, memory selects and captured data
    always @(posedge mclk) begin
        if (rst) begin
            addr_ff                 <= {`ADDR_WIDTH{1'h0}};
            program_memory_select_n <= 1'h1;
            data_memory_select_n    <= 1'h1;
            boot_memory_select_n    <= 1'h1;
            readStrobe_n            <= 1'h1;
            writeStrobe_n           <= 1'h1;
            rdDone_ff               <= 1'h0;
            rdData_ff               <= {`DATA_WIDTH{1'h0}};
        end else begin
            // done flag is a one-cycle pulse
            rdDone_ff     <= 1'h0;
            // no write path: write strobe stays inactive
            writeStrobe_n <= 1'h1;
            if (rdReady && rdReq) begin
                // start read: selects and strobe low
                addr_ff                 <= rdAddr;
                program_memory_select_n <= (rdSpace != `SPACE_PM);
                data_memory_select_n    <= (rdSpace != `SPACE_DM);
                boot_memory_select_n    <= (rdSpace != `SPACE_BM);
                readStrobe_n            <= 1'h0;
            end else if (state_ff[1] && waitCnt_ff == `WAIT_ZERO) begin
                // end of stretched strobe: capture data
                readStrobe_n            <= 1'h1;
                program_memory_select_n <= 1'h1;
                data_memory_select_n    <= 1'h1;
                boot_memory_select_n    <= 1'h1;
                rdData_ff               <= memData;
                rdDone_ff               <= 1'h1;
            end
        end
    end

    // strobes and selects float while released
    assign strobeOe = driveEn_ff;

endmodule

// ---- logic/ext_bus_consts.vh ----
// constants for the external pin interface block
// assumes a single 20 MHz processor clock, one clock per processor cycle
`ifndef EXT_BUS_CONSTS_VH
`define EXT_BUS_CONSTS_VH

`define CLK_PERIOD_NS      50
`define REQ_MIN_PULSE_NS   10
`define IRQ_COUNT          3
`define WAIT_WIDTH         3
`define ADDR_WIDTH         14
`define DATA_WIDTH         16
`define SPACE_PM           2'h0
`define SPACE_DM           2'h1
`define SPACE_BM           2'h2
`define SYNC_RESET_VAL     1'h1
`define WAIT_ZERO          3'h0
`define WAIT_ONE           3'h1

`endif

// ---- dv/ext_bus_sva.sv ----
// checker on the external pin interface ports
// assumes a bind onto the top module, one clock domain
`timescale 1ns/10ps
module ext_bus_sva (
    input wire       mclk, rst, bus_request_n, bus_grant_n, strobeOe, rdReq,
    input wire       rdReady, rdDone_ff, readStrobe_n, flag_input, flagSeen_ff,
    input wire       program_memory_select_n, data_memory_select_n,
    input wire       boot_memory_select_n,
    input wire [1:0] rdSpace,
    input wire [2:0] external_interrupt_n, irqSeen_ff, waitStates
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    reg [3:0] lowCnt_ff, strobeLen_ff; // strobe low count, expected length
    // measure each read strobe against its wait states
    always @(posedge mclk) begin
        if (rdReq && rdReady) strobeLen_ff <= waitStates + 4'h1;
        lowCnt_ff <= readStrobe_n ? 4'h0 : lowCnt_ff + 4'h1;
    end
    a_input_sample: assert property (!$past(rst) && !$past(rst, 2) |->
        irqSeen_ff == $past(external_interrupt_n, 2) &&
        flagSeen_ff == $past(flag_input, 2)) else $error("input sample");
    a_grant_delay: assert property (
        $fell(bus_request_n) && rdReady && !rdReq |-> ##[3:5] !bus_grant_n)
        else $error("grant late");
    a_grant_cause: assert property (
        $fell(bus_grant_n) |-> !$past(bus_request_n, 2)) else $error("grant");
    a_grant_hold: assert property (
        $rose(bus_grant_n) |-> $past(bus_request_n, 2)) else $error("ungrant");
    a_oe_off: assert property (!bus_grant_n |-> !strobeOe)
        else $error("oe on while granted");
    a_oe_first: assert property ($fell(strobeOe) |=> !bus_grant_n)
        else $error("oe order");
    a_oe_back: assert property (
        $rose(strobeOe) |-> $past(bus_grant_n) && bus_grant_n)
        else $error("oe back early");
    a_strobe_start: assert property (rdReq && rdReady |=>
        !readStrobe_n && $onehot({!program_memory_select_n,
        !data_memory_select_n, !boot_memory_select_n})) else $error("strobe");
    a_select_space: assert property (rdReq && rdReady |=>
        program_memory_select_n == ($past(rdSpace) != 2'h0) &&
        data_memory_select_n == ($past(rdSpace) != 2'h1) &&
        boot_memory_select_n == ($past(rdSpace) != 2'h2))
        else $error("select space");
    a_strobe_len: assert property ($rose(readStrobe_n) |->
        lowCnt_ff == strobeLen_ff && rdDone_ff) else $error("strobe length");
    c_grant: cover property ($fell(bus_grant_n));
    c_release: cover property ($rose(strobeOe));
    c_long_read: cover property ($rose(readStrobe_n) && strobeLen_ff == 4'h8);
endmodule
bind external_bus_interface ext_bus_sva chk_u (.mclk, .rst, .bus_request_n,
    .bus_grant_n, .strobeOe, .rdReq, .rdReady, .rdDone_ff, .readStrobe_n,
    .flag_input, .flagSeen_ff, .program_memory_select_n,
    .data_memory_select_n, .boot_memory_select_n, .external_interrupt_n,
    .irqSeen_ff, .waitStates, .rdSpace);

// ---- dv/ext_bus_partner.sv ----
// memory and bus master on the far side of the pins
// assumes the strobes change on the processor clock
`timescale 1ns/10ps
module ext_bus_partner (
    input  wire        mclk, want, strobeOe, strobeN, pSelN, dSelN,
    input  wire [13:0] addr_ff,
    output reg         bus_request_n,
    output wire [15:0] memData
);
    reg [15:0] last_ff = 16'h0; // last value on the data lines
    initial bus_request_n = 1'b1;
    // request moves off the clock edge, held whole cycles
    always @(want) bus_request_n <= #17 !want;
    // data only while read strobe low, else a toggling pattern
    assign memData = (strobeOe && !strobeN) ?
        {!pSelN, !dSelN, addr_ff} : ~last_ff;
    always @(posedge mclk) last_ff <= memData;
endmodule

// ---- dv/external_bus_interface_test.sv ----
// self-checking bench for the external pin interface
// assumes the partner model drives memory data and bus request
`timescale 1ns/10ps
module external_bus_interface_test;
    reg         mclk, rst, flag, rdReq, want;
    reg  [2:0]  irqN, waitSt;
    wire [2:0]  irqSeen_ff;
    reg  [1:0]  space;
    reg  [13:0] addr;
    wire [15:0] memData, rdData_ff;
    wire [13:0] addr_ff;
    wire        rdReady, rdDone_ff, flagSeen_ff, bus_grant_n, pSelN, dSelN;
    wire        bSelN, strobeN, strobeOe, bus_request_n, wrN;
    integer     num_errors = 0, checks = 0, n, i, k;
    external_bus_interface dut_u (.mclk, .rst, .external_interrupt_n(irqN),
        .flag_input(flag), .bus_request_n, .rdReq, .rdSpace(space),
        .rdAddr(addr), .waitStates(waitSt), .memData, .rdReady, .rdDone_ff,
        .rdData_ff, .irqSeen_ff, .flagSeen_ff, .bus_grant_n, .addr_ff,
        .program_memory_select_n(pSelN), .data_memory_select_n(dSelN),
        .boot_memory_select_n(bSelN), .readStrobe_n(strobeN),
        .writeStrobe_n(wrN), .strobeOe);
    ext_bus_partner far_u (.mclk, .want, .strobeOe, .strobeN, .pSelN, .dSelN,
        .addr_ff, .bus_request_n, .memData);
    task cmp(input [127:0] what, input [15:0] exp, got);
        checks = checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("FAIL %0s exp %h got %h", what, exp, got);
        end
    endtask
    task test_done;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // count falling edges until the wanted level, bounded
    task waitLvl(input integer sel, input lvl);
        n = 0;
        while ((sel ? rdDone_ff : bus_grant_n) !== lvl && n < 20) begin
            @(negedge mclk);
            n = n + 1;
        end
        if ((sel ? rdDone_ff : bus_grant_n) !== lvl) begin
            num_errors = num_errors + 1;
            $display("FAIL wait exp %h got timeout", lvl);
            test_done;
        end
    endtask
    // one read, checking latency and returned data
    task rd(input [1:0] s, input [2:0] w);
        @(posedge mclk);
        rdReq <= 1'b1;
        space <= s;
        waitSt <= w;
        addr <= 14'($urandom);
        k = 0;
        @(posedge mclk);
        while (rdReady !== 1'b1 && k < 20) begin
            @(posedge mclk);
            k = k + 1;
        end
        if (k == 20) begin
            num_errors = num_errors + 1;
            $display("FAIL ready exp 1 got timeout");
            test_done;
        end
        rdReq <= 1'b0;
        waitLvl(1, 1'b1);
        cmp("latency", w + 16'h2, n);
        cmp("data", {s == 2'h0, s == 2'h1, addr}, rdData_ff);
        cmp("addr", {2'h0, addr}, {2'h0, addr_ff});
    endtask
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        {rst, flag, rdReq, want, irqN, waitSt, space, addr} = {4'h8, 22'h380000};
        n = $urandom(61);
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        for (i = 0; i < 12; i = i + 1) rd(i % 3, i < 8 ? i : $urandom);
        for (i = 0; i < 6; i = i + 1) begin
            @(posedge mclk);
            {irqN, flag} <= 4'($urandom); // held 3 cycles
            repeat (3) @(negedge mclk);
            cmp("seen", {irqN, flag}, {irqSeen_ff, flagSeen_ff});
        end
        @(posedge mclk);
        want <= 1'b1;
        waitLvl(0, 1'b0);
        cmp("grant", 16'h5, n);
        @(posedge mclk);
        rdReq <= 1'b1;
        repeat (4) @(negedge mclk);
        cmp("held", 16'h0, {strobeOe, rdDone_ff, bus_grant_n});
        @(posedge mclk);
        {rdReq, want} <= 2'h0;
        waitLvl(0, 1'b1);
        cmp("release", 16'h4, n);
        @(negedge mclk);
        cmp("oe back", 16'h1, strobeOe);
        rd(2, 1);
        cmp("write idle", 16'h1, wrN);
        test_done;
    end
endmodule
